// File: rtl/dsh_stop_mode_ctrl.sv
`timescale 1ns/1ps
module dsh_stop_mode_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [31:0] od_wdata,
    output logic od_done,
    output logic od_error,
    output logic [31:0] od_rdata,
    input wire logic ev_shutdown,
    input wire logic ev_disable_op,
    input wire logic ev_quick_stop,
    input wire logic ev_fault,
    input wire logic ev_release,
    input wire logic standstill,
    input wire logic ref_found,
    output dsh_pkg::dsh_stop_cmd_t stop_cmd,
    output dsh_pkg::dsh_ramp_t halt_ramp,
    output dsh_pkg::dsh_mode_t active_control_mode,
    output logic homing_run,
    output logic homing_attained,
    output logic pos_load,
    output logic [31:0] pos_load_value
);

    // ****************************************
    // declarations
    // ****************************************
    dsh_pkg::dsh_options_t opts;
    dsh_pkg::dsh_stop_state_t state_reg;
    dsh_pkg::dsh_ramp_t plan_ramp;
    logic plan_hold;
    logic any_ev;
    logic hold_after_reg;
    logic [15:0] controlword_reg;
    logic [31:0] home_offset_reg;
    logic [7:0] requested_control_mode;
    logic opt_hit;
    logic opt_valid;
    logic od_ok;
    logic od_wr;
    logic homing_enable;
    logic [31:0] read_word;

    function automatic logic mode_ok(input logic [7:0] m);
        return (m == 8'h01) || (m == 8'h03) || (m == 8'h04) || (m == 8'h06) || (m == 8'h07);
    endfunction : mode_ok

    // ****************************************
    // option objects
    // ****************************************
    assign od_wr = od_req && od_write;

    dsh_option_regs u_opts (
        .clk(clk),
        .rst(rst),
        .wr_en(od_wr),
        .wr_index(od_index),
        .wr_data(od_wdata[15:0]),
        .opts(opts),
        .hit(opt_hit),
        .valid(opt_valid)
    );

    // ****************************************
    // object access decode
    // ****************************************
    always_comb begin
        case (od_index)
            dsh_pkg::IDX_CONTROLWORD: read_word = {16'h0000, controlword_reg};
            dsh_pkg::IDX_QUICK_STOP: read_word = {16'h0000, opts.quick_stop_reaction_select};
            dsh_pkg::IDX_SHUTDOWN: read_word = {16'h0000, opts.shutdown_reaction_select};
            dsh_pkg::IDX_DISABLE_OP: read_word = {16'h0000, opts.disable_op_reaction_select};
            dsh_pkg::IDX_HALT: read_word = {16'h0000, opts.halt_reaction_select};
            dsh_pkg::IDX_FAULT: read_word = {16'h0000, opts.fault_reaction_select};
            dsh_pkg::IDX_REQ_MODE: read_word = {24'h000000, requested_control_mode};
            dsh_pkg::IDX_ACT_MODE: read_word = {24'h000000, active_control_mode};
            dsh_pkg::IDX_HOME_OFFSET: read_word = home_offset_reg;
            default: read_word = 32'h0000_0000;
        endcase
        if (!od_write) begin
            od_ok = (od_index == dsh_pkg::IDX_CONTROLWORD) || opt_hit
                || (od_index == dsh_pkg::IDX_REQ_MODE) || (od_index == dsh_pkg::IDX_ACT_MODE)
                || (od_index == dsh_pkg::IDX_HOME_OFFSET);
        end else if (opt_hit) begin
            od_ok = opt_valid;
        end else if (od_index == dsh_pkg::IDX_REQ_MODE) begin
            od_ok = mode_ok(od_wdata[7:0]);
        end else begin
            od_ok = (od_index == dsh_pkg::IDX_CONTROLWORD)
                || (od_index == dsh_pkg::IDX_HOME_OFFSET);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            od_done <= 1'b0;
            od_error <= 1'b0;
            od_rdata <= 32'h0000_0000;
        end else begin
            od_done <= od_req;
            od_error <= od_req && !od_ok;
            if (od_req && !od_write) begin
                od_rdata <= read_word;
            end
        end
    end

    // ****************************************
    // controlword, home offset, requested mode
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            controlword_reg <= dsh_pkg::RST_CONTROLWORD;
            home_offset_reg <= dsh_pkg::RST_HOME_OFFSET;
            requested_control_mode <= dsh_pkg::RST_MODE;
        end else if (od_wr) begin
            if (od_index == dsh_pkg::IDX_CONTROLWORD) begin
                controlword_reg <= od_wdata[15:0];
            end
            if (od_index == dsh_pkg::IDX_HOME_OFFSET) begin
                home_offset_reg <= od_wdata;
            end
            if (od_index == dsh_pkg::IDX_REQ_MODE && mode_ok(od_wdata[7:0])) begin
                requested_control_mode <= od_wdata[7:0];
            end
        end
    end

    // ****************************************
    // mode in force, switched only when quiet
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            active_control_mode <= dsh_pkg::MODE_PROFILE_POS;
        end else if (state_reg == dsh_pkg::ST_IDLE && !homing_run) begin
            active_control_mode <= dsh_pkg::dsh_mode_t'(requested_control_mode);
        end
    end

    // ****************************************
    // reaction plan for the winning event
    // ****************************************
    always_comb begin
        logic [15:0] code;
        code = 16'h0000;
        any_ev = ev_quick_stop || ev_disable_op || ev_shutdown;
        if (ev_quick_stop) begin
            code = opts.quick_stop_reaction_select;
        end else if (ev_disable_op) begin
            code = opts.disable_op_reaction_select;
        end else if (ev_shutdown) begin
            code = opts.shutdown_reaction_select;
        end
        plan_hold = 1'b0;
        case (code)
            dsh_pkg::OPT_PROFILE_OFF: plan_ramp = dsh_pkg::RAMP_PROFILE;
            dsh_pkg::OPT_QUICK_OFF: plan_ramp = dsh_pkg::RAMP_QUICK;
            dsh_pkg::OPT_PROFILE_HOLD: begin
                plan_ramp = dsh_pkg::RAMP_PROFILE;
                plan_hold = 1'b1;
            end
            dsh_pkg::OPT_QUICK_HOLD: begin
                plan_ramp = dsh_pkg::RAMP_QUICK;
                plan_hold = 1'b1;
            end
            default: plan_ramp = dsh_pkg::RAMP_NONE;
        endcase
    end

    // ****************************************
    // stop reaction sequencer
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= dsh_pkg::ST_IDLE;
            stop_cmd <= '0;
            hold_after_reg <= 1'b0;
        end else if (ev_fault && state_reg != dsh_pkg::ST_COAST) begin
            state_reg <= dsh_pkg::ST_COAST;
            stop_cmd <= '{dsh_pkg::RAMP_NONE, 1'b0, 1'b1, 1'b0, 1'b1};
        end else begin
            case (state_reg)
                dsh_pkg::ST_IDLE: begin
                    if (any_ev && plan_ramp == dsh_pkg::RAMP_NONE) begin
                        state_reg <= dsh_pkg::ST_OFF;
                        stop_cmd <= '{dsh_pkg::RAMP_NONE, 1'b1, 1'b1, 1'b0, 1'b0};
                    end else if (any_ev) begin
                        state_reg <= dsh_pkg::ST_RAMP;
                        stop_cmd <= '{plan_ramp, 1'b0, 1'b0, 1'b0, 1'b0};
                        hold_after_reg <= plan_hold;
                    end
                end
                dsh_pkg::ST_RAMP: begin
                    if (standstill && hold_after_reg) begin
                        state_reg <= dsh_pkg::ST_HOLD_QS;
                        stop_cmd <= '{dsh_pkg::RAMP_NONE, 1'b0, 1'b0, 1'b1, 1'b0};
                    end else if (standstill) begin
                        state_reg <= dsh_pkg::ST_OFF;
                        stop_cmd <= '{dsh_pkg::RAMP_NONE, 1'b0, 1'b1, 1'b0, 1'b0};
                    end
                end
                dsh_pkg::ST_OFF, dsh_pkg::ST_HOLD_QS, dsh_pkg::ST_COAST: begin
                    if (ev_release) begin
                        state_reg <= dsh_pkg::ST_IDLE;
                        stop_cmd <= '0;
                    end
                end
                default: begin
                    state_reg <= dsh_pkg::ST_IDLE;
                    stop_cmd <= '0;
                end
            endcase
        end
    end

    // ****************************************
    // halt ramp selection
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_ramp <= dsh_pkg::RAMP_NONE;
        end else if (state_reg != dsh_pkg::ST_IDLE || !controlword_reg[dsh_pkg::CW_HALT_BIT]) begin
            halt_ramp <= dsh_pkg::RAMP_NONE;
        end else if (active_control_mode == dsh_pkg::MODE_HOMING) begin
            halt_ramp <= dsh_pkg::RAMP_HOMING;
        end else if (opts.halt_reaction_select == dsh_pkg::OPT_HALT_URGENT) begin
            halt_ramp <= dsh_pkg::RAMP_QUICK;
        end else begin
            halt_ramp <= dsh_pkg::RAMP_PROFILE;
        end
    end

    // ****************************************
    // homing
    // ****************************************
    assign homing_enable = (active_control_mode == dsh_pkg::MODE_HOMING)
        && (state_reg == dsh_pkg::ST_IDLE);

    dsh_homing u_homing (
        .clk(clk),
        .rst(rst),
        .enable(homing_enable),
        .cmd_start(controlword_reg[dsh_pkg::CW_HOME_START_BIT]),
        .cmd_halt(controlword_reg[dsh_pkg::CW_HALT_BIT]),
        .ref_found(ref_found),
        .home_offset(home_offset_reg),
        .run(homing_run),
        .attained(homing_attained),
        .pos_load(pos_load),
        .pos_load_value(pos_load_value)
    );

    // ****************************************
    // checks
    // ****************************************
    a_fault_coast: assert property (@(posedge clk) disable iff (rst)
        ev_fault |=> stop_cmd.coast && stop_cmd.power_off && stop_cmd.ramp == dsh_pkg::RAMP_NONE)
        else $error("fault did not coast the motor");
    a_shut_zero: assert property (@(posedge clk) disable iff (rst)
        state_reg == dsh_pkg::ST_IDLE && ev_shutdown && !ev_quick_stop && !ev_disable_op
        && !ev_fault && opts.shutdown_reaction_select == 16'h0000
        |=> stop_cmd.method_stop && stop_cmd.power_off)
        else $error("shutdown option 0 did not use stop method");
    a_disop_ramp: assert property (@(posedge clk) disable iff (rst)
        state_reg == dsh_pkg::ST_IDLE && ev_disable_op && !ev_quick_stop && !ev_fault
        && opts.disable_op_reaction_select == 16'h0001 ##1 !ev_fault && standstill
        |=> stop_cmd.power_off && stop_cmd.ramp == dsh_pkg::RAMP_NONE)
        else $error("disable operation option 1 did not ramp then cut power");
    a_qs_default: assert property (@(posedge clk) disable iff (rst)
        state_reg == dsh_pkg::ST_IDLE && ev_quick_stop && !ev_fault
        && opts.quick_stop_reaction_select == 16'h0002
        |=> stop_cmd.ramp == dsh_pkg::RAMP_QUICK && !stop_cmd.power_off)
        else $error("quick stop option 2 did not use quick ramp");
    a_qs_hold: assert property (@(posedge clk) disable iff (rst)
        state_reg == dsh_pkg::ST_RAMP && hold_after_reg && standstill && !ev_fault
        |=> stop_cmd.hold_qs && !stop_cmd.power_off)
        else $error("quick stop 5 or 6 did not stay in quick stop");
    a_halt_default: assert property (@(posedge clk) disable iff (rst)
        state_reg == dsh_pkg::ST_IDLE && controlword_reg[8] && opts.halt_reaction_select == 16'h0
        && active_control_mode != dsh_pkg::MODE_HOMING |=> halt_ramp == dsh_pkg::RAMP_PROFILE)
        else $error("halt option 0 not treated as normal ramp");
    a_mode_readonly: assert property (@(posedge clk) disable iff (rst)
        od_req && od_write && od_index == dsh_pkg::IDX_ACT_MODE |=> od_done && od_error)
        else $error("write to mode display not refused");
    a_mode_follows: assert property (@(posedge clk) disable iff (rst)
        $changed(active_control_mode) |-> active_control_mode == $past(requested_control_mode)
        && $past(state_reg) == dsh_pkg::ST_IDLE)
        else $error("active mode changed to other than the requested mode");
    c_qs_hold: cover property (@(posedge clk) disable iff (rst)
        state_reg == dsh_pkg::ST_RAMP ##[1:20] state_reg == dsh_pkg::ST_HOLD_QS);
    c_fault: cover property (@(posedge clk) disable iff (rst)
        state_reg == dsh_pkg::ST_RAMP ##1 state_reg == dsh_pkg::ST_COAST);
    c_halt_urgent: cover property (@(posedge clk) disable iff (rst)
        halt_ramp == dsh_pkg::RAMP_QUICK);

endmodule : dsh_stop_mode_ctrl

// File: rtl/dsh_pkg.sv
package dsh_pkg;

    // ****************************************
    // object indices
    // ****************************************
    localparam logic [15:0] IDX_CONTROLWORD = 16'h6040;
    localparam logic [15:0] IDX_QUICK_STOP = 16'h605A;
    localparam logic [15:0] IDX_SHUTDOWN = 16'h605B;
    localparam logic [15:0] IDX_DISABLE_OP = 16'h605C;
    localparam logic [15:0] IDX_HALT = 16'h605D;
    localparam logic [15:0] IDX_FAULT = 16'h605E;
    localparam logic [15:0] IDX_REQ_MODE = 16'h6060;
    localparam logic [15:0] IDX_ACT_MODE = 16'h6061;
    localparam logic [15:0] IDX_HOME_OFFSET = 16'h607C;

    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [15:0] RST_QUICK_STOP = 16'h0002;
    localparam logic [15:0] RST_SHUTDOWN = 16'h0000;
    localparam logic [15:0] RST_DISABLE_OP = 16'h0000;
    localparam logic [15:0] RST_HALT = 16'h0000;
    localparam logic [15:0] RST_FAULT = 16'h0000;
    localparam logic [7:0] RST_MODE = 8'h01;
    localparam logic [15:0] RST_CONTROLWORD = 16'h0000;
    localparam logic [31:0] RST_HOME_OFFSET = 32'h0000_0000;
    localparam int CW_HOME_START_BIT = 4;
    localparam int CW_HALT_BIT = 8;

    // ****************************************
    // option codes
    // ****************************************
    localparam logic [15:0] OPT_OFF = 16'h0000;
    localparam logic [15:0] OPT_PROFILE_OFF = 16'h0001;
    localparam logic [15:0] OPT_QUICK_OFF = 16'h0002;
    localparam logic [15:0] OPT_PROFILE_HOLD = 16'h0005;
    localparam logic [15:0] OPT_QUICK_HOLD = 16'h0006;
    localparam logic [15:0] OPT_HALT_URGENT = 16'h0002;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [7:0] {
        MODE_PROFILE_POS = 8'h01,
        MODE_PROFILE_VEL = 8'h03,
        MODE_PROFILE_TRQ = 8'h04,
        MODE_HOMING = 8'h06,
        MODE_INTERP_POS = 8'h07
    } dsh_mode_t;

    typedef enum logic [1:0] {
        RAMP_NONE = 2'h0,
        RAMP_PROFILE = 2'h1,
        RAMP_QUICK = 2'h2,
        RAMP_HOMING = 2'h3
    } dsh_ramp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RAMP = 3'h1,
        ST_OFF = 3'h2,
        ST_HOLD_QS = 3'h3,
        ST_COAST = 3'h4
    } dsh_stop_state_t;

    typedef struct packed {
        dsh_ramp_t ramp;
        logic method_stop;
        logic power_off;
        logic hold_qs;
        logic coast;
    } dsh_stop_cmd_t;

    typedef struct packed {
        logic [15:0] quick_stop_reaction_select;
        logic [15:0] shutdown_reaction_select;
        logic [15:0] disable_op_reaction_select;
        logic [15:0] halt_reaction_select;
        logic [15:0] fault_reaction_select;
    } dsh_options_t;

endpackage : dsh_pkg

// File: rtl/dsh_option_regs.sv
`timescale 1ns/1ps
module dsh_option_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [15:0] wr_index,
    input wire logic [15:0] wr_data,
    output dsh_pkg::dsh_options_t opts,
    output logic hit,
    output logic valid
);

    // ****************************************
    // range check per option object
    // ****************************************
    function automatic logic value_ok(input logic [15:0] idx, input logic [15:0] v);
        logic ok;
        ok = 1'b0;
        case (idx)
            dsh_pkg::IDX_QUICK_STOP: ok = (v <= 16'h0002) || (v == 16'h0005) || (v == 16'h0006);
            dsh_pkg::IDX_SHUTDOWN: ok = (v <= 16'h0001);
            dsh_pkg::IDX_DISABLE_OP: ok = (v <= 16'h0001);
            dsh_pkg::IDX_HALT: ok = (v == 16'h0001) || (v == 16'h0002);
            dsh_pkg::IDX_FAULT: ok = (v == 16'h0000);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : value_ok

    always_comb begin
        hit = (wr_index >= dsh_pkg::IDX_QUICK_STOP) && (wr_index <= dsh_pkg::IDX_FAULT);
        valid = value_ok(wr_index, wr_data);
    end

    // ****************************************
    // storage, bad values leave contents alone
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            opts.quick_stop_reaction_select <= dsh_pkg::RST_QUICK_STOP;
            opts.shutdown_reaction_select <= dsh_pkg::RST_SHUTDOWN;
            opts.disable_op_reaction_select <= dsh_pkg::RST_DISABLE_OP;
            opts.halt_reaction_select <= dsh_pkg::RST_HALT;
            opts.fault_reaction_select <= dsh_pkg::RST_FAULT;
        end else if (wr_en && valid) begin
            case (wr_index)
                dsh_pkg::IDX_QUICK_STOP: opts.quick_stop_reaction_select <= wr_data;
                dsh_pkg::IDX_SHUTDOWN: opts.shutdown_reaction_select <= wr_data;
                dsh_pkg::IDX_DISABLE_OP: opts.disable_op_reaction_select <= wr_data;
                dsh_pkg::IDX_HALT: opts.halt_reaction_select <= wr_data;
                default: opts.fault_reaction_select <= wr_data;
            endcase
        end
    end

    a_reject_bad_value: assert property (@(posedge clk) disable iff (rst)
        wr_en && !valid |=> $stable(opts))
        else $error("option changed on a refused write");
    a_halt_range: assert property (@(posedge clk) disable iff (rst)
        $changed(opts.halt_reaction_select) |-> opts.halt_reaction_select inside {16'h0001, 16'h0002})
        else $error("halt option took a value outside its range");

endmodule : dsh_option_regs

// File: rtl/dsh_homing.sv
`timescale 1ns/1ps
module dsh_homing (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic cmd_start,
    input wire logic cmd_halt,
    input wire logic ref_found,
    input wire logic [31:0] home_offset,
    output logic run,
    output logic attained,
    output logic pos_load,
    output logic [31:0] pos_load_value
);

    logic start_prev_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            start_prev_reg <= 1'b0;
        end else begin
            start_prev_reg <= cmd_start;
        end
    end

    // ****************************************
    // start, abort and completion
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            run <= 1'b0;
            attained <= 1'b0;
            pos_load <= 1'b0;
            pos_load_value <= 32'h0000_0000;
        end else begin
            pos_load <= 1'b0;
            if (!enable || !cmd_start) begin
                run <= 1'b0;
            end else if (!cmd_halt) begin
                if (!start_prev_reg) begin
                    run <= 1'b1;
                    attained <= 1'b0;
                end else if (run && ref_found) begin
                    run <= 1'b0;
                    attained <= 1'b1;
                    pos_load <= 1'b1;
                    pos_load_value <= home_offset;
                end
            end
        end
    end

    a_abort_on_fall: assert property (@(posedge clk) disable iff (rst)
        $fell(cmd_start) |=> !run && !pos_load)
        else $error("homing kept running after start bit fell");
    a_offset_load: assert property (@(posedge clk) disable iff (rst)
        pos_load |-> pos_load_value == $past(home_offset) && attained && !run)
        else $error("position not loaded with home offset");
    a_halt_blocks: assert property (@(posedge clk) disable iff (rst)
        cmd_halt && !run |=> !run)
        else $error("homing started while halt set");
    c_homing_done: cover property (@(posedge clk) disable iff (rst)
        run ##[1:20] pos_load);

endmodule : dsh_homing

// File: bench/dsh_master_model.sv
`timescale 1ns/1ps
// ****************************************
// master side of the object port
// ****************************************
module dsh_master_model (
    input wire logic clk,
    output logic od_req,
    output logic od_write,
    output logic [15:0] od_index,
    output logic [31:0] od_wdata
);
    initial {od_req, od_write, od_index, od_wdata} = 50'h0;
    // released lines show inverted data, not the last value
    task automatic access(logic w, logic [15:0] i, logic [31:0] d);
        @(negedge clk);
        {od_req, od_write, od_index, od_wdata} = {1'b1, w, i, d};
        @(negedge clk);
        {od_req, od_write, od_index, od_wdata} = {1'b0, ~w, ~i, ~d};
    endtask : access
endmodule : dsh_master_model

// File: bench/test_dsh_stop_mode_ctrl.sv
`timescale 1ns/1ps
module test_dsh_stop_mode_ctrl;
    // ****************************************
    // bench
    // ****************************************
    logic clk, rst, od_req, od_write, od_done, od_error, pos_load, run, att;
    logic ev_sd, ev_do, ev_qs, ev_flt, ev_rel, still, ref_found;
    logic [15:0] od_index;
    logic [31:0] od_wdata, od_rdata, pos_val, v;
    dsh_pkg::dsh_stop_cmd_t stop_cmd;
    dsh_pkg::dsh_ramp_t halt_ramp;
    dsh_pkg::dsh_mode_t act;
    int n_mismatch = 0;
    int compares = 0;
    logic [15:0] qs[5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
    logic [15:0] ri[7] = '{16'h605A, 16'h605B, 16'h605C, 16'h605D, 16'h605E, 16'h6060, 16'h6061};
    logic [7:0] md[5] = '{8'h01, 8'h03, 8'h04, 8'h07, 8'h06};
    dsh_master_model i_dsh_master_model (.clk(clk), .od_req(od_req), .od_write(od_write),
        .od_index(od_index), .od_wdata(od_wdata));
    dsh_stop_mode_ctrl i_dsh_stop_mode_ctrl (.clk(clk), .rst(rst), .od_req(od_req),
        .od_write(od_write), .od_index(od_index), .od_wdata(od_wdata), .od_done(od_done),
        .od_error(od_error), .od_rdata(od_rdata), .ev_shutdown(ev_sd), .ev_disable_op(ev_do),
        .ev_quick_stop(ev_qs), .ev_fault(ev_flt), .ev_release(ev_rel), .standstill(still),
        .ref_found(ref_found), .stop_cmd(stop_cmd), .halt_ramp(halt_ramp),
        .active_control_mode(act), .homing_run(run), .homing_attained(att),
        .pos_load(pos_load), .pos_load_value(pos_val));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic acc(logic w, logic [15:0] i, logic [31:0] d, logic err);
        i_dsh_master_model.access(w, i, d);
        chk("od_done", od_done, 1);
        chk("od_error", od_error, err);
    endtask : acc
    task automatic cw(logic [31:0] d);
        acc(1, 16'h6040, d, 0);
        repeat (2) @(negedge clk);
    endtask : cw
    function automatic logic [5:0] exp_ramp(logic [15:0] o);
        return (o == 16'h0000) ? 6'h0C : (o == 16'h0002 || o == 16'h0006) ? 6'h20 : 6'h10;
    endfunction : exp_ramp
    function automatic logic [5:0] exp_rest(logic [15:0] o);
        return (o == 16'h0000) ? 6'h0C : (o > 16'h0004) ? 6'h02 : 6'h04;
    endfunction : exp_rest
    // e: 0 shutdown, 1 disable operation, 2 quick stop
    task automatic stop_seq(int e, logic [15:0] o);
        acc(1, e == 0 ? 16'h605B : e == 1 ? 16'h605C : 16'h605A, {16'h0000, o}, 0);
        {ev_qs, ev_do, ev_sd} = 3'h1 << e;
        @(negedge clk);
        {ev_qs, ev_do, ev_sd} = 3'h0;
        chk("stop_ramp", stop_cmd, exp_ramp(o));
        still = 1;
        @(negedge clk);
        {still, ev_rel} = 2'h1;
        chk("stop_rest", stop_cmd, exp_rest(o));
        @(negedge clk);
        ev_rel = 0;
    endtask : stop_seq
    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        {rst, ev_sd, ev_do, ev_qs, ev_flt, ev_rel, still, ref_found} = 8'h80;
        void'($urandom(32'hE9EB));
        repeat (10) @(negedge clk);
        rst = 0;
        foreach (ri[k]) begin
            acc(0, ri[k], 0, 0);
            chk("reset_val", od_rdata, k == 0 ? 2 : k > 4 ? 1 : 0);
        end
        acc(1, 16'h6061, 32'h0000_0003, 1);
        acc(1, 16'h605E, 32'h0000_0001, 1);
        acc(1, 16'h605A, 32'h0000_0003, 1);
        acc(0, 16'h605A, 0, 0);
        chk("qs_kept", od_rdata, 2);
        repeat (8) begin
            v = $urandom % 4;
            acc(1, 16'h605B, v, v > 1);
        end
        foreach (qs[k]) stop_seq(2, qs[k]);
        repeat (6) stop_seq($urandom % 2, $urandom % 2);
        ev_qs = 1;
        @(negedge clk);
        {ev_qs, ev_flt} = 2'h1;
        chk("qs_ramp", stop_cmd, 6'h20);
        @(negedge clk);
        {ev_flt, ev_rel} = 2'h1;
        chk("fault", stop_cmd, 6'h05);
        @(negedge clk);
        ev_rel = 0;
        cw(32'h0000_0100);
        chk("halt_dflt", halt_ramp, 1);
        cw(0);
        acc(1, 16'h605D, 2, 0);
        cw(32'h0000_0100);
        chk("halt_urg", halt_ramp, 2);
        cw(0);
        foreach (md[k]) begin
            acc(1, 16'h6060, md[k], 0);
            @(negedge clk);
            chk("mode", act, md[k]);
            acc(0, 16'h6061, 0, 0);
            chk("mode_rd", od_rdata, md[k]);
        end
        acc(1, 16'h6060, 2, 1);
        acc(1, 16'h607C, 32'h1234_ABCD, 0);
        cw(32'h0000_0110);
        chk("home_halt", {run, halt_ramp}, 3);
        cw(0);
        cw(32'h0000_0010);
        chk("run", run, 1);
        ref_found = 1;
        @(negedge clk);
        ref_found = 0;
        chk("load", pos_load, 1);
        chk("attained", att, 1);
        chk("load_val", pos_val, 32'h1234_ABCD);
        cw(0);
        cw(32'h0000_0010);
        cw(0);
        chk("abort", run, 0);
        report_and_stop();
    end
endmodule : test_dsh_stop_mode_ctrl
